// file: stcd_core_model.sv
// Microprogram side model that answers forwarded commands
`default_nettype none
module stcd_core_model (
   input  wire logic       clk_i,
   input  wire logic       start_i,
   input  wire logic       abort_i,
   input  wire logic [7:0] delay_i,
   output var  logic       done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial done_o = 1'b0;
   // Done only ever follows a start, delay_i + 1 cycles after it
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      if (abort_i) begin
         cnt <= 0;
      end else if (start_i) begin
         cnt <= int'(delay_i) + 1;
      end else if (cnt == 1) begin
         done_o <= 1'b1;
         cnt    <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule : stcd_core_model
`default_nettype wire

// file: stcd_hold_timer.sv
// Down counter that holds a busy flag for a set number of cycles
`default_nettype none
module stcd_hold_timer #(
   parameter int CYCLES = 3
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic start_i,
   output var  logic busy_o
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q  <= '0;
         busy_o <= 1'b0;
      end else if (start_i) begin
         cnt_q  <= W'(CYCLES - 1);
         busy_o <= 1'b1;
      end else if (cnt_q != '0) begin
         cnt_q  <= cnt_q - W'(1);
      end else begin
         busy_o <= 1'b0;
      end
   end
endmodule : stcd_hold_timer
`default_nettype wire

// file: stcd_pkg.sv
// Constants for the SCSI target command decoder
`default_nettype none
package stcd_pkg;
   localparam logic [7:0] ADR_CORE_STATE = 8'h50;
   localparam logic [7:0] ADR_COMMAND    = 8'h53;
   localparam logic [7:0] ADR_DATA_DRIVE = 8'h57;
   localparam logic [7:0] ADR_CTRL_DRIVE = 8'h5E;
   localparam logic [7:0] ADR_EVENT_2    = 8'h72;
   localparam int BIT_RUNNING  = 0;
   localparam int BIT_CTRL_EN  = 1;
   localparam int BIT_DATA_EN  = 2;
   localparam int BIT_DONE     = 7;
   localparam int BIT_IGNORED  = 6;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [1:0] CAT_HOUSE  = 2'h0;
   localparam logic [1:0] CAT_DISC   = 2'h1;
   localparam logic [1:0] CAT_TARGET = 2'h2;
   localparam logic [1:0] CAT_STREAM = 2'h3;
   localparam logic [7:0] CMD_NOP        = 8'h00;
   localparam logic [7:0] CMD_CHIP_RESET = 8'h01;
   localparam logic [7:0] CMD_FLUSH      = 8'h03;
   localparam logic [7:0] CMD_CTRL_ON    = 8'h04;
   localparam logic [7:0] CMD_CTRL_OFF   = 8'h05;
   localparam logic [7:0] CMD_DATA_ON    = 8'h06;
   localparam logic [7:0] CMD_DATA_OFF   = 8'h07;
   localparam logic [7:0] CMD_SEL_ON     = 8'h08;
   localparam logic [7:0] CMD_SEL_OFF    = 8'h09;
   localparam logic [5:0] DISC_LAST      = 6'h03;
   localparam logic [3:0] TGT_RSVD_A     = 4'h2;
   localparam logic [3:0] TGT_RSVD_B     = 4'h3;
   localparam logic [3:0] TGT_SEQ_FIRST  = 4'h8;
   localparam logic [3:0] TGT_SEQ_LAST   = 4'hC;
   localparam logic [5:0] STREAM_LAST    = 6'h04;
   localparam int CLK_PERIOD_NS  = 50;
   localparam int CMD_GAP_NS     = 150;
   localparam int CMD_GAP_CYCLES = (CMD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_MICRO} stcd_state_e;
endpackage : stcd_pkg
`default_nettype wire

// file: stcd_rst_sync.sv
// Two-flop release of the asynchronous reset
`default_nettype none
module stcd_rst_sync (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   output var  logic rst_n_o
);
   logic meta_q;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q  <= 1'b0;
         rst_n_o <= 1'b0;
      end else begin
         meta_q  <= 1'b1;
         rst_n_o <= meta_q;
      end
   end
endmodule : stcd_rst_sync
`default_nettype wire

// file: stcd_top.sv
// Command front end of the SCSI target core
// What this block does
// - Category 00 commands run in any state
// - Category 01 runs only while disconnected
// - Category 10 runs only in target mode
// - Sequence codes 8 to C need bits 5:4 zero
// - Stream codes 0 to 4, other bits zero
// - No-op only raises function done
// - Running flag high until the command completes or is ignored
// - Chip reset clears the block registers
// - Chip reset decoded in hardware, aborts command
// - Flush empties the FIFO, no interrupt
// - Assert control drives set bits at once
// - Microcode status meaningless for housekeeping commands
// - Release control stops drive, keeps register
// - Assert data drives data register, bypasses FIFO
//
// Local design decision: strobed register access.
`default_nettype none
module stcd_top (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output var  logic [7:0] rdata_o,
   input  wire logic       disconnected_i,
   input  wire logic       target_mode_i,
   input  wire logic       micro_done_i,
   output var  logic [7:0] micro_cmd_o,
   output var  logic       micro_start_o,
   output var  logic       chip_reset_o,
   output var  logic       fifo_flush_o,
   output var  logic       fifo_bypass_o,
   output var  logic [7:0] ctrl_line_o,
   output var  logic [7:0] data_line_o,
   output var  logic       data_line_oe_o,
   output var  logic       wait_request_o
);
   ////////////////////////////////////////////////////////////////////////
   logic                 rst_n;
   stcd_pkg::stcd_state_e state_q;
   logic [7:0]           cmd_q;
   logic                 running_q;
   logic                 ctrl_en_q;
   logic [7:0]           ctrl_q;
   logic [7:0]           data_q;
   logic [1:0]           ev_q;
   logic                 cmd_wr;
   logic                 chip_rst;
   logic                 accept;
   logic                 allowed;
   logic [1:0]           cat;
   logic [5:0]           low;

   stcd_rst_sync u_rst (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .rst_n_o   (rst_n)
   );

   assign cmd_wr   = wr_i && (addr_i == stcd_pkg::ADR_COMMAND);
   // Decoded straight off the bus so it works even mid-command
   assign chip_rst = cmd_wr && (wdata_i == stcd_pkg::CMD_CHIP_RESET);
   // A command write while busy is dropped unless it is chip reset; the issuer is meant to wait anyway
   assign accept   = cmd_wr && !chip_rst && (state_q == stcd_pkg::ST_IDLE);
   assign cat      = cmd_q[7:6];
   assign low      = cmd_q[5:0];

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      allowed = 1'b0;
      case (cat)
         stcd_pkg::CAT_HOUSE:
            allowed = (cmd_q <= stcd_pkg::CMD_SEL_OFF) && (cmd_q != 8'h02);
         stcd_pkg::CAT_DISC:
            allowed = disconnected_i && (low <= stcd_pkg::DISC_LAST);
         stcd_pkg::CAT_TARGET: begin
            if (low[3:0] < stcd_pkg::TGT_SEQ_FIRST) begin
               allowed = target_mode_i && (low[3:0] != stcd_pkg::TGT_RSVD_A)
                         && (low[3:0] != stcd_pkg::TGT_RSVD_B);
            end else begin
               allowed = target_mode_i && (low[5:4] == 2'h0)
                         && (low[3:0] <= stcd_pkg::TGT_SEQ_LAST);
            end
         end
         default:
            allowed = (low <= stcd_pkg::STREAM_LAST);
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q       <= stcd_pkg::ST_IDLE;
         cmd_q         <= stcd_pkg::RESET_VALUE;
         running_q     <= 1'b0;
         micro_start_o <= 1'b0;
         micro_cmd_o   <= stcd_pkg::RESET_VALUE;
      end else if (chip_rst) begin
         state_q       <= stcd_pkg::ST_IDLE;
         cmd_q         <= stcd_pkg::RESET_VALUE;
         running_q     <= 1'b0;
         micro_start_o <= 1'b0;
      end else begin
         micro_start_o <= 1'b0;
         case (state_q)
            stcd_pkg::ST_IDLE: begin
               if (accept) begin
                  cmd_q     <= wdata_i;
                  running_q <= 1'b1;
                  state_q   <= stcd_pkg::ST_EXEC;
               end
            end
            stcd_pkg::ST_EXEC: begin
               if (allowed && (cat != stcd_pkg::CAT_HOUSE
                               || cmd_q == stcd_pkg::CMD_SEL_ON
                               || cmd_q == stcd_pkg::CMD_SEL_OFF)) begin
                  micro_cmd_o   <= cmd_q;
                  micro_start_o <= 1'b1;
                  state_q       <= stcd_pkg::ST_MICRO;
               end else begin
                  running_q <= 1'b0;
                  state_q   <= stcd_pkg::ST_IDLE;
               end
            end
            stcd_pkg::ST_MICRO: begin
               if (micro_done_i) begin
                  running_q <= 1'b0;
                  state_q   <= stcd_pkg::ST_IDLE;
               end
            end
            default: state_q <= stcd_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic exec_house;
   assign exec_house = (state_q == stcd_pkg::ST_EXEC) && allowed && (cat == stcd_pkg::CAT_HOUSE);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_en_q     <= 1'b0;
         fifo_bypass_o <= 1'b0;
         fifo_flush_o  <= 1'b0;
      end else if (chip_rst) begin
         ctrl_en_q     <= 1'b0;
         fifo_bypass_o <= 1'b0;
         fifo_flush_o  <= 1'b0;
      end else begin
         fifo_flush_o <= exec_house && (cmd_q == stcd_pkg::CMD_FLUSH);
         if (exec_house && cmd_q == stcd_pkg::CMD_CTRL_ON) begin
            ctrl_en_q <= 1'b1;
         end else if (exec_house && cmd_q == stcd_pkg::CMD_CTRL_OFF) begin
            ctrl_en_q <= 1'b0;
         end
         if (exec_house && cmd_q == stcd_pkg::CMD_DATA_ON) begin
            fifo_bypass_o <= 1'b1;
         end else if (exec_house && cmd_q == stcd_pkg::CMD_DATA_OFF) begin
            fifo_bypass_o <= 1'b0;
         end
      end
   end

   // Drive registers; release keeps their content
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= stcd_pkg::RESET_VALUE;
         data_q <= stcd_pkg::RESET_VALUE;
      end else if (chip_rst) begin
         ctrl_q <= stcd_pkg::RESET_VALUE;
         data_q <= stcd_pkg::RESET_VALUE;
      end else if (wr_i && addr_i == stcd_pkg::ADR_CTRL_DRIVE) begin
         ctrl_q <= wdata_i;
      end else if (wr_i && addr_i == stcd_pkg::ADR_DATA_DRIVE) begin
         data_q <= wdata_i;
      end
   end

   // Pins follow the registers one cycle later, no gating by command state
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_line_o    <= stcd_pkg::RESET_VALUE;
         data_line_o    <= stcd_pkg::RESET_VALUE;
         data_line_oe_o <= 1'b0;
      end else begin
         ctrl_line_o    <= ctrl_en_q ? ctrl_q : stcd_pkg::RESET_VALUE;
         data_line_o    <= data_q;
         data_line_oe_o <= fifo_bypass_o;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic done_set;
   logic ign_set;
   logic [1:0] ev_clr;
   assign done_set = (state_q == stcd_pkg::ST_MICRO && micro_done_i)
                     || (exec_house && cmd_q == stcd_pkg::CMD_NOP);
   assign ign_set  = (state_q == stcd_pkg::ST_EXEC) && !allowed;
   assign ev_clr   = (wr_i && addr_i == stcd_pkg::ADR_EVENT_2)
                     ? {wdata_i[stcd_pkg::BIT_DONE], wdata_i[stcd_pkg::BIT_IGNORED]} : 2'h0;

   // Set beats a write-one clear in the same cycle
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ev_q <= 2'h0;
      end else if (chip_rst) begin
         ev_q <= 2'h0;
      end else begin
         ev_q <= (ev_q & ~ev_clr) | {done_set, ign_set};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic gap_start;
   logic gap_busy;
   assign gap_start = accept || chip_rst;

   stcd_hold_timer #(.CYCLES(stcd_pkg::CMD_GAP_CYCLES)) u_gap (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .start_i (gap_start),
      .busy_o  (gap_busy)
   );

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wait_request_o <= 1'b0;
         chip_reset_o   <= 1'b0;
      end else begin
         // One pin for every command, so software need not know which ones interrupt
         wait_request_o <= gap_start || gap_busy;
         chip_reset_o   <= chip_rst;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= stcd_pkg::RESET_VALUE;
      end else if (rd_i) begin
         if (addr_i == stcd_pkg::ADR_CORE_STATE) begin
            rdata_o <= {5'h00, fifo_bypass_o, ctrl_en_q, running_q};
         end else if (addr_i == stcd_pkg::ADR_CTRL_DRIVE) begin
            rdata_o <= ctrl_q;
         end else if (addr_i == stcd_pkg::ADR_DATA_DRIVE) begin
            rdata_o <= data_q;
         end else if (addr_i == stcd_pkg::ADR_EVENT_2) begin
            rdata_o <= {ev_q, 6'h00};
         end else begin
            rdata_o <= stcd_pkg::RESET_VALUE;
         end
      end else begin
         rdata_o <= stcd_pkg::RESET_VALUE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   run_set_a: assert property (accept |=> running_q)
      else $error("running flag not set");
   nop_done_a: assert property (accept && wdata_i == stcd_pkg::CMD_NOP |=> ##1 ev_q[1] && !running_q)
      else $error("no-op did not complete");
   chip_rst_a: assert property (chip_rst |=> !running_q && !ctrl_en_q && !fifo_bypass_o && ev_q == 2'h0)
      else $error("chip reset left state");
   chip_out_a: assert property (chip_rst |=> chip_reset_o ##1 !micro_start_o)
      else $error("chip reset pulse missing");
   flush_a: assert property (accept && wdata_i == stcd_pkg::CMD_FLUSH |=> ##1 fifo_flush_o && !$rose(ev_q[1]))
      else $error("flush misbehaved");
   ctrl_drive_a: assert property (ctrl_en_q && !chip_rst |=> ctrl_line_o == $past(ctrl_q))
      else $error("control lines not driven");
   ctrl_rel_a: assert property (!ctrl_en_q |=> ctrl_line_o == 8'h00)
      else $error("control lines not released");
   disc_ign_a: assert property (state_q == stcd_pkg::ST_EXEC && cat == stcd_pkg::CAT_DISC && !disconnected_i
                                && !chip_rst |=> ev_q[0] && !micro_start_o)
      else $error("disallowed command ran");
   gap_a: assert property (accept |=> wait_request_o [*3])
      else $error("wait request too short");
   data_mode_a: assert property (fifo_bypass_o && !chip_rst |=> data_line_oe_o)
      else $error("data drive not enabled");
   ign_flag_a: assert property (state_q == stcd_pkg::ST_EXEC && !allowed && !chip_rst
                                |=> ev_q[0] && !running_q && !micro_start_o)
      else $error("ignored command not flagged");
   house_fwd_a: assert property (micro_start_o && micro_cmd_o[7:6] == stcd_pkg::CAT_HOUSE
                                 |-> micro_cmd_o[3])
      else $error("housekeeping command forwarded");
   run_clr_a: assert property ($rose(ev_q[1]) |-> !running_q)
      else $error("running flag stuck after done");
   bypass_off_a: assert property (chip_rst |=> ##1 !data_line_oe_o)
      else $error("data drive survived chip reset");

   nop_c: cover property (accept && wdata_i == stcd_pkg::CMD_NOP ##2 ev_q[1]);
   micro_c: cover property (micro_start_o ##[1:20] micro_done_i);
   ign_c: cover property ($rose(ev_q[0]));
   abort_c: cover property (state_q == stcd_pkg::ST_MICRO && chip_rst);
   flush_c: cover property (fifo_flush_o);
endmodule : stcd_top
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the command front end
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, micro_cmd_o, ctrl_line_o, data_line_o;
   logic       disconnected_i = 1'b0, target_mode_i = 1'b0, micro_done_i;
   logic       micro_start_o, chip_reset_o, fifo_flush_o, fifo_bypass_o, data_line_oe_o, wait_request_o;
   logic [7:0] dly = 8'h02, v;
   int         n_errors = 0, samples_checked = 0, n_start = 0, n_flush = 0, n_crst = 0, i;
   logic [9:0] tbl [14] = '{{8'h40, 2'b00}, {8'h40, 2'b10}, {8'h43, 2'b10}, {8'h84, 2'b00},
                            {8'h94, 2'b01}, {8'h82, 2'b01}, {8'h88, 2'b01}, {8'h98, 2'b01},
                            {8'hC4, 2'b00}, {8'hC5, 2'b00}, {8'hD0, 2'b00}, {8'h02, 2'b00},
                            {8'h08, 2'b00}, {8'h09, 2'b00}};
   logic [0:13] tgo = 14'b01101010100011;

   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      n_start <= n_start + int'(micro_start_o);
      n_flush <= n_flush + int'(fifo_flush_o);
      n_crst  <= n_crst + int'(chip_reset_o);
   end

   stcd_top stcd_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .disconnected_i(disconnected_i),
      .target_mode_i(target_mode_i), .micro_done_i(micro_done_i), .micro_cmd_o(micro_cmd_o),
      .micro_start_o(micro_start_o), .chip_reset_o(chip_reset_o), .fifo_flush_o(fifo_flush_o),
      .fifo_bypass_o(fifo_bypass_o), .ctrl_line_o(ctrl_line_o), .data_line_o(data_line_o),
      .data_line_oe_o(data_line_oe_o), .wait_request_o(wait_request_o));
   stcd_core_model stcd_core_model_inst (.clk_i(clk_i), .start_i(micro_start_o),
      .abort_i(chip_reset_o), .delay_i(dly), .done_o(micro_done_i));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      rd_i <= 1'b1; addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask : rd
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(d, e);
   endtask : rdchk
   // Holds off while the block asks for a gap, bounded so a stuck flag cannot hang
   task automatic send(input logic [7:0] c);
      int k;
      @(negedge clk_i);
      for (k = 0; k < 20 && wait_request_o !== 1'b0; k++) @(negedge clk_i);
      chk({7'h00, wait_request_o}, 8'h00);
      wr(stcd_pkg::ADR_COMMAND, c);
   endtask : send
   task automatic wait_idle();
      logic [7:0] s;
      int k;
      s = 8'h01;
      for (k = 0; k < 100 && s[0] !== 1'b0; k++) rd(stcd_pkg::ADR_CORE_STATE, s);
      chk({7'h00, s[0]}, 8'h00);
   endtask : wait_idle

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_nop();
      int s0, f0;
      s0 = n_start; f0 = n_flush;
      send(stcd_pkg::CMD_NOP);
      wait_idle();
      rdchk(stcd_pkg::ADR_EVENT_2, 8'h80);
      chk(8'(n_start - s0 + n_flush - f0), 8'h00);
      wr(stcd_pkg::ADR_EVENT_2, 8'h80);
      rdchk(stcd_pkg::ADR_EVENT_2, 8'h00);
   endtask : t_nop
   task automatic t_flush();
      int f0;
      f0 = n_flush;
      send(stcd_pkg::CMD_FLUSH);
      @(negedge clk_i);
      chk({7'h00, wait_request_o}, 8'h01);
      wait_idle();
      chk(8'(n_flush - f0), 8'h01);
      rdchk(stcd_pkg::ADR_EVENT_2, 8'h00);
   endtask : t_flush
   task automatic t_ctrl();
      wr(stcd_pkg::ADR_CTRL_DRIVE, 8'hA5);
      chk(ctrl_line_o, 8'h00);
      rdchk(stcd_pkg::ADR_CTRL_DRIVE, 8'hA5);
      send(stcd_pkg::CMD_CTRL_ON);
      wait_idle();
      chk(ctrl_line_o, 8'hA5);
      rdchk(stcd_pkg::ADR_CORE_STATE, 8'h02);
      rdchk(stcd_pkg::ADR_EVENT_2, 8'h00);
      wr(stcd_pkg::ADR_CTRL_DRIVE, 8'h5A);
      repeat (2) @(negedge clk_i);
      chk(ctrl_line_o, 8'h5A);
      send(stcd_pkg::CMD_CTRL_OFF);
      wait_idle();
      chk(ctrl_line_o, 8'h00);
      rdchk(stcd_pkg::ADR_CTRL_DRIVE, 8'h5A);
   endtask : t_ctrl
   task automatic t_data_reset();
      int c0;
      c0 = n_crst;
      send(stcd_pkg::CMD_DATA_ON);
      wait_idle();
      wr(stcd_pkg::ADR_DATA_DRIVE, 8'h3C);
      repeat (2) @(negedge clk_i);
      chk(data_line_o, 8'h3C);
      chk({6'h00, fifo_bypass_o, data_line_oe_o}, 8'h03);
      send(stcd_pkg::CMD_DATA_OFF);
      wait_idle();
      @(negedge clk_i);
      chk({6'h00, fifo_bypass_o, data_line_oe_o}, 8'h00);
      send(stcd_pkg::CMD_DATA_ON);
      wait_idle();
      send(stcd_pkg::CMD_CHIP_RESET);
      repeat (stcd_pkg::CMD_GAP_CYCLES + 2) @(negedge clk_i);
      chk({6'h00, fifo_bypass_o, data_line_oe_o}, 8'h00);
      chk(data_line_o, 8'h00);
      chk(8'(n_crst - c0), 8'h01);
      rdchk(stcd_pkg::ADR_CTRL_DRIVE, 8'h00);
      rdchk(stcd_pkg::ADR_CORE_STATE, 8'h00);
   endtask : t_data_reset
   // Each entry: command, disconnected, target mode; tgo gives whether it must be forwarded
   task automatic t_gate(input logic [9:0] e, input logic go);
      int s0;
      @(posedge clk_i);
      disconnected_i <= e[1]; target_mode_i <= e[0];
      s0 = n_start;
      send(e[9:2]);
      wait_idle();
      rdchk(stcd_pkg::ADR_EVENT_2, go ? 8'h80 : 8'h40);
      chk(8'(n_start - s0), {7'h00, go});
      if (go) chk(micro_cmd_o, e[9:2]);
      wr(stcd_pkg::ADR_EVENT_2, 8'hC0);
   endtask : t_gate
   task automatic t_abort();
      @(posedge clk_i);
      disconnected_i <= 1'b1; dly <= 8'd30;
      send(8'h41);
      rdchk(stcd_pkg::ADR_CORE_STATE, 8'h01);
      wr(stcd_pkg::ADR_COMMAND, stcd_pkg::CMD_CHIP_RESET);
      repeat (stcd_pkg::CMD_GAP_CYCLES + 2) @(negedge clk_i);
      rdchk(stcd_pkg::ADR_CORE_STATE, 8'h00);
      repeat (40) @(negedge clk_i);
      rdchk(stcd_pkg::ADR_EVENT_2, 8'h00);
      dly <= 8'd10;
      send(8'h40);
      rdchk(stcd_pkg::ADR_CORE_STATE, 8'h01);
      wait_idle();
      rdchk(stcd_pkg::ADR_EVENT_2, 8'h80);
   endtask : t_abort

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("errors %0d, checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   initial begin
      #2_000_000;
      n_errors++;
      stop_test();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rdchk(stcd_pkg::ADR_CORE_STATE, 8'h00);
      rdchk(stcd_pkg::ADR_EVENT_2, 8'h00);
      rdchk(8'h61, 8'h00);
      t_nop();
      t_flush();
      t_ctrl();
      t_data_reset();
      for (i = 0; i < 14; i++) t_gate(tbl[i], tgo[i]);
      t_abort();
      stop_test();
   end
endmodule : testbench
`default_nettype wire
